// ===== flyback_protection_supervisor.sv
`timescale 1ns/1ns
`default_nettype none

module flyback_protection_supervisor #(
	parameter logic [31:0] OCP_DELAY_TICKS = 32'(flyback_pkg::OCP_DELAY_CYC),
	parameter logic [31:0] SCP_TICKS = 32'(flyback_pkg::SCP_DEBOUNCE_CYC),
	parameter logic [31:0] TEMP_LONG_TICKS = 32'(flyback_pkg::TEMP_LONG_CYC),
	parameter logic [31:0] TEMP_SHORT_TICKS = 32'(flyback_pkg::TEMP_SHORT_CYC)
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cs_over_limit,
	input wire logic i_cs_over_fb,
	input wire logic i_cs_over_ocp,
	input wire logic i_fb_above_olp,
	input wire logic i_fb_below_lowpower,
	input wire logic i_vdd_above_on,
	input wire logic i_vdd_below_undervoltage_lockout,
	input wire logic i_vdd_below_fault_off,
	input wire logic i_vdd_below_release,
	input wire logic i_vdd_below_scp,
	input wire logic i_vdd_over_limit,
	input wire logic i_temp_below_high,
	input wire logic i_temp_below_ext,
	input wire logic [3:0] i_line_level,
	output logic o_gate,
	output logic [7:0] o_limit_level,
	output logic [7:0] o_ocp_level,
	output logic o_fault_latched,
	output logic o_low_current,
	output logic o_temp_enable
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [flyback_pkg::NUM_IN-1:0] raw;
	logic [flyback_pkg::NUM_IN-1:0] pin;

	assign raw = {i_line_level, i_temp_below_ext, i_temp_below_high, i_vdd_over_limit,
		i_vdd_below_scp, i_vdd_below_release, i_vdd_below_fault_off, i_vdd_below_undervoltage_lockout,
		i_vdd_above_on, i_fb_below_lowpower, i_fb_above_olp, i_cs_over_ocp,
		i_cs_over_fb, i_cs_over_limit};

	// Three stages; a change counts only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < flyback_pkg::NUM_IN; gi++) begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					pin[gi] <= 1'b0;
				end else begin
					s1 <= raw[gi];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						pin[gi] <= s3;
					end
				end
			end
		end
	endgenerate

	logic cs_limit, cs_fb, cs_ocp, fb_olp, fb_low;
	logic vdd_on, vdd_undervoltage_lockout, vdd_off, vdd_rel, vdd_scp, vdd_ovp;
	logic temp_high, temp_ext;
	logic [3:0] line;

	assign cs_limit = pin[flyback_pkg::IN_CS_LIMIT];
	assign cs_fb = pin[flyback_pkg::IN_CS_FB];
	assign cs_ocp = pin[flyback_pkg::IN_CS_OCP];
	assign fb_olp = pin[flyback_pkg::IN_FB_OLP];
	assign fb_low = pin[flyback_pkg::IN_FB_LOW];
	assign vdd_on = pin[flyback_pkg::IN_VDD_ON];
	assign vdd_undervoltage_lockout = pin[flyback_pkg::IN_VDD_UNDERVOLTAGE_LOCKOUT];
	assign vdd_off = pin[flyback_pkg::IN_VDD_OFF];
	assign vdd_rel = pin[flyback_pkg::IN_VDD_REL];
	assign vdd_scp = pin[flyback_pkg::IN_VDD_SCP];
	assign vdd_ovp = pin[flyback_pkg::IN_VDD_OVP];
	assign temp_high = pin[flyback_pkg::IN_TEMP_HIGH];
	assign temp_ext = pin[flyback_pkg::IN_TEMP_EXT];
	assign line = pin[flyback_pkg::IN_LINE_LSB +: 4];

	// ----------------------------------------
	// Supply sequencing and protection latch
	// ----------------------------------------
	flyback_pkg::supply_state_t state;
	flyback_pkg::supply_state_t next_state;
	logic fault;
	logic ocp_hit, scp_hit, temp_long_hit, temp_short_hit;

	// Turn-off threshold depends on whether a fault is latched
	always_comb begin
		next_state = state;
		unique case (state)
			flyback_pkg::ST_OFF: begin
				if (vdd_on) begin
					next_state = fault ? flyback_pkg::ST_FAULT_RUN : flyback_pkg::ST_RUN;
				end
			end
			flyback_pkg::ST_RUN: begin
				if (fault) begin
					next_state = flyback_pkg::ST_FAULT_RUN;
				end else if (vdd_undervoltage_lockout) begin
					next_state = flyback_pkg::ST_OFF;
				end
			end
			flyback_pkg::ST_FAULT_RUN: begin
				if (vdd_off) begin
					next_state = flyback_pkg::ST_FAULT_HOLD;
				end
			end
			flyback_pkg::ST_FAULT_HOLD: begin
				if (vdd_rel) begin
					next_state = flyback_pkg::ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= flyback_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Only a power-on reset releases the latch; nothing else clears it
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			fault <= 1'b0;
		end else if (vdd_ovp || ocp_hit || scp_hit || temp_long_hit || temp_short_hit) begin
			fault <= 1'b1;
		end
	end

	assign o_fault_latched = fault;
	assign o_low_current = (state == flyback_pkg::ST_FAULT_HOLD);

	// ----------------------------------------
	// Switching period and gate
	// ----------------------------------------
	logic [9:0] period_cnt;
	logic [9:0] on_cnt;
	logic period_start;
	logic gate_allowed;
	logic blank_done;
	logic end_pulse;

	assign period_start = (period_cnt == flyback_pkg::PERIOD_LAST);
	assign gate_allowed = (state == flyback_pkg::ST_RUN) && !fault;
	assign blank_done = (on_cnt >= flyback_pkg::BLANK_LEN);
	assign end_pulse = (blank_done && (cs_limit || cs_fb))
		|| (on_cnt == flyback_pkg::MAX_ON_LAST);

	// Free-running fixed-frequency oscillator
	always_ff @(posedge i_mclk) begin
		if (i_rst || period_start) begin
			period_cnt <= 10'h000;
		end else begin
			period_cnt <= period_cnt + 10'h001;
		end
	end

	// Each pulse judged on its own: any cycle may be cut short
	always_ff @(posedge i_mclk) begin
		if (i_rst || !gate_allowed) begin
			o_gate <= 1'b0;
		end else if (period_start) begin
			o_gate <= 1'b1;
		end else if (o_gate && end_pulse) begin
			o_gate <= 1'b0;
		end
	end

	// On-time counter feeds blanking and maximum duty
	always_ff @(posedge i_mclk) begin
		if (i_rst || !o_gate) begin
			on_cnt <= 10'h000;
		end else begin
			on_cnt <= on_cnt + 10'h001;
		end
	end

	// ----------------------------------------
	// Line compensation and soft-start
	// ----------------------------------------
	logic [7:0] line_limit;
	logic [7:0] ss_ramp;
	logic [11:0] ss_div;

	// Line code is slow, so a bit-wise crossing is tolerable here
	assign line_limit = flyback_pkg::LIMIT_BASE - 8'(line * flyback_pkg::LIMIT_STEP);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ocp_level <= flyback_pkg::OCP_BASE;
		end else begin
			o_ocp_level <= flyback_pkg::OCP_BASE - 8'(line * flyback_pkg::OCP_STEP);
		end
	end

	// Step enable divider and ramp restart on every entry to run
	always_ff @(posedge i_mclk) begin
		if (i_rst || state != flyback_pkg::ST_RUN) begin
			ss_div <= 12'h000;
			ss_ramp <= 8'h00;
		end else if (ss_div == flyback_pkg::SS_STEP_LAST) begin
			ss_div <= 12'h000;
			if (ss_ramp != flyback_pkg::RAMP_TOP) begin
				ss_ramp <= ss_ramp + 8'h01;
			end
		end else begin
			ss_div <= ss_div + 12'h001;
		end
	end

	// Lower of the ramp and the line-compensated level
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_limit_level <= 8'h00;
		end else begin
			o_limit_level <= (ss_ramp < line_limit) ? ss_ramp : line_limit;
		end
	end

	// ----------------------------------------
	// Over-current, short and temperature timers
	// ----------------------------------------
	logic peak_over;
	logic ocp_run;
	logic scp_cond;
	logic temp_long_cond;
	logic temp_short_cond;

	// Record whether this pulse's peak crossed the threshold
	always_ff @(posedge i_mclk) begin
		if (i_rst || period_start) begin
			peak_over <= 1'b0;
		end else if (o_gate && blank_done && cs_ocp) begin
			peak_over <= 1'b1;
		end
	end

	// A clean or missing pulse breaks the run of over-threshold pulses
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ocp_run <= 1'b0;
		end else if (period_start) begin
			ocp_run <= peak_over;
		end
	end

	assign scp_cond = fb_olp && vdd_scp;
	assign o_temp_enable = !fb_low;
	assign temp_long_cond = temp_high && !fb_low;
	assign temp_short_cond = temp_ext && !fb_low;

	// One qualifying timer per latched protection path except over-voltage, which latches directly
	debounce_timer u_ocp (.i_mclk(i_mclk), .i_rst(i_rst), .i_cond(ocp_run),
		.i_ticks(OCP_DELAY_TICKS), .o_hit(ocp_hit));
	debounce_timer u_scp (.i_mclk(i_mclk), .i_rst(i_rst), .i_cond(scp_cond),
		.i_ticks(SCP_TICKS), .o_hit(scp_hit));
	debounce_timer u_temp_long (.i_mclk(i_mclk), .i_rst(i_rst), .i_cond(temp_long_cond),
		.i_ticks(TEMP_LONG_TICKS), .o_hit(temp_long_hit));
	debounce_timer u_temp_short (.i_mclk(i_mclk), .i_rst(i_rst), .i_cond(temp_short_cond),
		.i_ticks(TEMP_SHORT_TICKS), .o_hit(temp_short_hit));

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_limit_ends_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_gate && blank_done && cs_limit && !period_start |=> !o_gate)
		else $error("pulse not ended by current limit");
	chk_line_lowers_limit: assert property (@(posedge i_mclk) disable iff (i_rst)
		line > $past(line) |-> line_limit < $past(line_limit))
		else $error("limit did not fall with higher line");
	chk_ocp_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
		ocp_hit |=> fault ##1 !o_gate)
		else $error("over-current did not latch gate off");
	chk_ocp_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
		period_start && !peak_over |=> !ocp_run ##1 !ocp_hit)
		else $error("clean pulse did not restart over-current delay");
	chk_ocp_line: assert property (@(posedge i_mclk) disable iff (i_rst)
		line > $past(line) |=> o_ocp_level < $past(o_ocp_level))
		else $error("over-current level did not fall with line");
	chk_scp_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
		scp_hit |=> fault)
		else $error("short protection did not latch");
	chk_undervoltage_lockout_normal: assert property (@(posedge i_mclk) disable iff (i_rst)
		state == flyback_pkg::ST_RUN && !fault && vdd_undervoltage_lockout
		|=> state == flyback_pkg::ST_OFF ##1 !o_gate)
		else $error("normal lockout not honoured");
	chk_fault_turnoff: assert property (@(posedge i_mclk) disable iff (i_rst)
		state == flyback_pkg::ST_FAULT_RUN && vdd_off |=> o_low_current && !o_gate)
		else $error("fault turn-off level not honoured");
	chk_hold_until_release: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_low_current && !vdd_rel |=> o_low_current)
		else $error("reduced current left before release level");
	chk_blank_window: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_gate && gate_allowed && !blank_done |=> o_gate)
		else $error("pulse ended inside blanking");
	chk_ovp_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
		vdd_ovp |=> fault)
		else $error("over-voltage did not latch");
	chk_softstart_ramp: assert property (@(posedge i_mclk) disable iff (i_rst)
		state != flyback_pkg::ST_RUN |=> ss_ramp == 8'h00 ##1 o_limit_level == 8'h00)
		else $error("soft-start ramp not restarted");
	chk_temp_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
		temp_long_hit || temp_short_hit |=> fault)
		else $error("temperature protection did not latch");
	chk_temp_ext_path: assert property (@(posedge i_mclk) disable iff (i_rst)
		!temp_short_cond |=> !temp_short_hit)
		else $error("external latch timer kept running");
	chk_temp_disabled: assert property (@(posedge i_mclk) disable iff (i_rst)
		fb_low [*2] |-> !temp_long_hit && !temp_short_hit && !o_temp_enable)
		else $error("temperature function active at low feedback");
	chk_latch_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
		fault |=> fault && !o_gate)
		else $error("protection latch released without reset");

endmodule

`default_nettype wire

// ===== flyback_debounce.sv
// Contract
// - End pulse when sense exceeds limit level
// - Higher line voltage gives lower limit level
// - Sustained over-current peaks latch gate off
// - Short surges ignored; clean pulse restarts delay
// - Over-current threshold follows line like limit
// - Open loop with low supply latches off
// - Normal turn-off at fixed lockout level
// - After fault, turn-off uses higher level
// - Below fault level: hold current until release
// - Ignore limit comparator during turn-on blanking
// - Supply over-voltage latches protection
// - Limit level ramps up during soft-start
// - Long temperature-low period latches protection
// - Short external-latch pull-down latches protection
// - Low feedback disables temperature pin function
`timescale 1ns/1ns
`default_nettype none

package flyback_pkg;

	// ----------------------------------------
	// Clock and switching timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int CLK_HZ = CLK_MHZ * 1_000_000;
	localparam int SWITCH_HZ = 65_000;
	localparam int PERIOD_CYC = CLK_HZ / SWITCH_HZ;
	localparam int MAX_ON_PCT = 75;
	localparam int MAX_ON_CYC = PERIOD_CYC * MAX_ON_PCT / 100;
	localparam int BLANK_NS = 300;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam logic [9:0] PERIOD_LAST = 10'(PERIOD_CYC - 1);
	localparam logic [9:0] MAX_ON_LAST = 10'(MAX_ON_CYC - 1);
	localparam logic [9:0] BLANK_LEN = 10'(BLANK_CYC);

	// ----------------------------------------
	// Soft-start: 256 ramp steps over the interval
	// ----------------------------------------
	localparam int SOFTSTART_US = 6000;
	localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;
	localparam logic [11:0] SS_STEP_LAST = 12'(SOFTSTART_CYC / 256 - 1);

	// ----------------------------------------
	// Debounce times (least times, rounded up)
	// ----------------------------------------
	localparam int OCP_DELAY_US = 100_000;
	localparam int OCP_DELAY_CYC = OCP_DELAY_US * CLK_MHZ;
	localparam int SCP_DEBOUNCE_US = 20_000;
	localparam int SCP_DEBOUNCE_CYC = SCP_DEBOUNCE_US * CLK_MHZ;
	localparam int TEMP_LONG_US = 14_000;
	localparam int TEMP_LONG_CYC = TEMP_LONG_US * CLK_MHZ;
	localparam int TEMP_SHORT_NS = 165_000;
	localparam int TEMP_SHORT_CYC = (TEMP_SHORT_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Line compensation of the two sense levels
	// ----------------------------------------
	localparam logic [7:0] LIMIT_BASE = 8'hF0;
	localparam logic [7:0] LIMIT_STEP = 8'h08;
	localparam logic [7:0] OCP_BASE = 8'hD0;
	localparam logic [7:0] OCP_STEP = 8'h07;
	localparam logic [7:0] RAMP_TOP = 8'hFF;

	// ----------------------------------------
	// Synchronised pin positions
	// ----------------------------------------
	localparam int IN_CS_LIMIT = 0;
	localparam int IN_CS_FB = 1;
	localparam int IN_CS_OCP = 2;
	localparam int IN_FB_OLP = 3;
	localparam int IN_FB_LOW = 4;
	localparam int IN_VDD_ON = 5;
	localparam int IN_VDD_UNDERVOLTAGE_LOCKOUT = 6;
	localparam int IN_VDD_OFF = 7;
	localparam int IN_VDD_REL = 8;
	localparam int IN_VDD_SCP = 9;
	localparam int IN_VDD_OVP = 10;
	localparam int IN_TEMP_HIGH = 11;
	localparam int IN_TEMP_EXT = 12;
	localparam int IN_LINE_LSB = 13;
	localparam int NUM_IN = 17;

	// Supply sequencing states
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_FAULT_RUN = 2'b10,
		ST_FAULT_HOLD = 2'b11
	} supply_state_t;

endpackage

module debounce_timer (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cond,
	input wire logic [31:0] i_ticks,
	output logic o_hit
);

	logic [31:0] count;

	// ----------------------------------------
	// Qualify a condition held for i_ticks cycles
	// ----------------------------------------
	// Any drop of the condition restarts the wait from zero
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_cond) begin
			count <= 32'h0000_0000;
			o_hit <= 1'b0;
		end else if (count >= i_ticks) begin
			o_hit <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
		end
	end

	chk_drop_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_cond |=> !o_hit && count == 32'h0000_0000)
		else $error("debounce not cleared after condition drop");

endmodule

`default_nettype wire

// ===== flyback_front_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Sense comparators seen from the gate side
// ----------------------------------------
module analog_front_model (
	input wire logic i_mclk,
	input wire logic i_gate,
	input wire logic [9:0] i_limit_cycles,
	input wire logic [9:0] i_ocp_cycles,
	input wire logic i_ocp_enable,
	output logic o_cs_over_limit,
	output logic o_cs_over_ocp
);
	logic [9:0] on_time;

	// Sense current ramps only while the switch conducts
	always_ff @(posedge i_mclk) begin
		on_time <= i_gate ? on_time + 10'h001 : 10'h000;
	end

	// Sense is zero with the switch off, so both comparators drop then
	assign o_cs_over_limit = i_gate && (on_time >= i_limit_cycles);
	assign o_cs_over_ocp = i_gate && i_ocp_enable && (on_time >= i_ocp_cycles);
endmodule

`default_nettype wire

// ===== flyback_protection_supervisor_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module flyback_protection_supervisor_tb_top;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic cs_lim, cs_ocp, fb_olp, fb_low, vdd_on, vdd_undervoltage_lockout, vdd_foff, vdd_rel;
	logic vdd_scp, vdd_ovp, t_high, t_ext, ocp_en, cs_fb;
	logic [3:0] line;
	logic [9:0] lim_cyc;
	logic o_gate, o_fault_latched, o_low_current, o_temp_enable;
	logic [7:0] o_limit_level, o_ocp_level;
	int mismatches = 0;
	int comparisons = 0;

	always #10 i_mclk = ~i_mclk;

	// Short debounce counts keep the run brief
	flyback_protection_supervisor #(.OCP_DELAY_TICKS(32'd1600), .SCP_TICKS(32'd20),
		.TEMP_LONG_TICKS(32'd30), .TEMP_SHORT_TICKS(32'd10)) dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_over_limit(cs_lim),
		.i_cs_over_fb(cs_fb), .i_cs_over_ocp(cs_ocp), .i_fb_above_olp(fb_olp),
		.i_fb_below_lowpower(fb_low), .i_vdd_above_on(vdd_on),
		.i_vdd_below_undervoltage_lockout(vdd_undervoltage_lockout), .i_vdd_below_fault_off(vdd_foff),
		.i_vdd_below_release(vdd_rel), .i_vdd_below_scp(vdd_scp),
		.i_vdd_over_limit(vdd_ovp), .i_temp_below_high(t_high),
		.i_temp_below_ext(t_ext), .i_line_level(line), .o_gate(o_gate),
		.o_limit_level(o_limit_level), .o_ocp_level(o_ocp_level),
		.o_fault_latched(o_fault_latched), .o_low_current(o_low_current),
		.o_temp_enable(o_temp_enable));

	analog_front_model front (.i_mclk(i_mclk), .i_gate(o_gate), .i_limit_cycles(lim_cyc),
		.i_ocp_cycles(10'd30), .i_ocp_enable(ocp_en), .o_cs_over_limit(cs_lim),
		.o_cs_over_ocp(cs_ocp));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask

	// ----------------------------------------
	// Bounded waits and stimulus helpers
	// ----------------------------------------
	// Returns cycles spent before the matching one; sel 0 watches the gate, 1 the latch
	task automatic wait_out(input int sel, input logic lvl, input int bound, output int n);
		for (n = 0; n < bound; n++) begin
			@(negedge i_mclk);
			if ((sel == 0 ? o_gate : o_fault_latched) === lvl) begin
				return;
			end
		end
		mismatches++;
		$display("mismatch at %0t: wait ran out on output %h", $time, sel);
		give_verdict();
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	task automatic pulse_width(output int w);
		int n;
		wait_out(0, 1'b1, 2000, n);
		wait_out(0, 1'b0, 1000, w);
		w = w + 1; // The edge that raised the gate counts too
	endtask

	// Every pin idle, then five cycles of reset
	task automatic do_reset;
		@(negedge i_mclk);
		{fb_olp, fb_low, vdd_on, vdd_undervoltage_lockout, vdd_foff, vdd_rel} = '0;
		{vdd_scp, vdd_ovp, t_high, t_ext, ocp_en, cs_fb} = '0;
		line = 4'h0;
		lim_cyc = 10'd100;
		i_rst = 1'b1;
		cycles(5);
		i_rst = 1'b0;
		cycles(2);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_levels;
		do_reset();
		for (int k = 0; k < 16; k++) begin
			line = 4'(k);
			cycles(8);
			check_val(o_ocp_level, 8'hD0 - 8'(7 * k));
		end
		check_val(o_gate, 1'b0);
		$display("test levels done");
	endtask

	task automatic t_gate;
		int w;
		do_reset();
		vdd_on = 1'b1;
		cycles(4000);
		check_in(o_limit_level, 8'h02, 8'h04);
		lim_cyc = 10'd5;
		pulse_width(w);
		check_in(w, 16, 20);
		lim_cyc = 10'd100;
		pulse_width(w);
		check_in(w, 103, 107);
		check_in(o_limit_level, 8'h03, 8'hF0);
		vdd_foff = 1'b1;
		pulse_width(w);
		check_in(w, 103, 107);
		vdd_undervoltage_lockout = 1'b1;
		vdd_on = 1'b0;
		cycles(10);
		for (w = 0; w < 1600 && o_gate !== 1'b1; w++) @(negedge i_mclk);
		check_val(w, 1600);
		check_val(o_low_current, 1'b0);
		$display("test gate done");
	endtask

	task automatic t_ocp;
		int w;
		do_reset();
		vdd_on = 1'b1;
		ocp_en = 1'b1;
		pulse_width(w);
		pulse_width(w);
		ocp_en = 1'b0;
		repeat (3) pulse_width(w);
		check_val(o_fault_latched, 1'b0);
		ocp_en = 1'b1;
		wait_out(1, 1'b1, 6000, w);
		cycles(3);
		for (w = 0; w < 1600 && o_gate !== 1'b1; w++) @(negedge i_mclk);
		check_val(w, 1600);
		vdd_foff = 1'b1;
		cycles(8);
		check_val(o_low_current, 1'b1);
		vdd_rel = 1'b1;
		vdd_on = 1'b0;
		cycles(8);
		check_val(o_low_current, 1'b0);
		{vdd_foff, vdd_rel, vdd_on} = 3'b001;
		for (w = 0; w < 1600 && o_gate !== 1'b1; w++) @(negedge i_mclk);
		check_val(w, 1600);
		check_val(o_fault_latched, 1'b1);
		$display("test overcurrent done");
	endtask

	task automatic t_short;
		int n;
		do_reset();
		fb_olp = 1'b1;
		cycles(40);
		vdd_scp = 1'b1;
		cycles(15);
		vdd_scp = 1'b0;
		cycles(10);
		check_val(o_fault_latched, 1'b0);
		vdd_scp = 1'b1;
		wait_out(1, 1'b1, 60, n);
		check_in(n, 22, 30);
		$display("test short done");
	endtask

	task automatic t_temp;
		int n;
		do_reset();
		t_ext = 1'b1;
		cycles(8);
		t_ext = 1'b0;
		cycles(10);
		check_val(o_fault_latched, 1'b0);
		fb_low = 1'b1;
		t_ext = 1'b1;
		cycles(40);
		check_val(o_temp_enable, 1'b0);
		check_val(o_fault_latched, 1'b0);
		fb_low = 1'b0;
		wait_out(1, 1'b1, 60, n);
		check_in(n, 13, 20);
		do_reset();
		t_high = 1'b1;
		wait_out(1, 1'b1, 80, n);
		check_in(n, 32, 40);
		do_reset();
		check_val(o_fault_latched, 1'b0);
		vdd_ovp = 1'b1;
		wait_out(1, 1'b1, 20, n);
		check_in(n, 2, 8);
		$display("test temperature and overvoltage done");
	endtask

	// Feedback path, maximum duty and fixed full-frequency period
	task automatic t_feedback;
		int w;
		int n;
		do_reset();
		vdd_on = 1'b1;
		lim_cyc = 10'h3FF;
		pulse_width(w);
		check_val(w, flyback_pkg::MAX_ON_CYC);
		wait_out(0, 1'b1, 1000, n);
		check_val(w + n + 1, flyback_pkg::PERIOD_CYC);
		wait_out(0, 1'b0, 1000, n);
		cs_fb = 1'b1;
		pulse_width(w);
		check_val(w, flyback_pkg::BLANK_CYC + 1);
		$display("test feedback done");
	endtask

	initial begin
		t_levels();
		t_gate();
		t_feedback();
		t_ocp();
		t_short();
		t_temp();
		give_verdict();
	end
endmodule

`default_nettype wire
